// ### rtcc_control.sv
// Functional notes
// - Coding bit selects binary (0) or BCD (1) for all time registers.
// - Hour-mode bit set gives 12-hour with PM top bit; clear forces it zero.
// - Writing one to counter-stop halts seconds counter; zero lets it run.
// - Counter status bit reads one while seconds counter is stopped.
// - Alarm-stop bit resets to one; one suppresses alarms, zero enables.
// - Alarm status bit resets to one and shows real alarm halt state.
// - Three-bit periodic selector, default minute: off, sec, min, hour, day, month.
// - Each periodic pulse lasts exactly one 32kHz time base cycle.
// - Periodic output held off while counter-stopped status is high.
// - Square-wave selector: 0 off, 1 gives 1Hz, doubling up to 16384Hz.
// - Trim may lengthen low time by at most eight 32kHz cycles at rollover.
// - Summary register holds one bit per source group at fixed positions.
// - Summary bits reset to zero and clear when the summary is read.
// - Periodic, seconds and alarm flags set on rising edge, clear on read.
// - Hours count 0-23 or 1-12; bit 5 is the PM flag in 12-hour mode.
// - An all-ones alarm field is a wildcard matching any value.
`timescale 1ns/100ps
`default_nettype none
module rtcc_control #(
  parameter int CORE_HZ_P = rtcc_pkg::CORE_HZ
) (
  // Clock and reset
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  RSTN_I,
  // Register port behind the serial control interface
  input  wire rtcc_pkg::rtcc_regreq_t REG_REQ_I,
  output logic [15:0]                REG_RDATA_O,
  output logic                       REG_RVALID_O,
  // Time counter side
  input  wire rtcc_pkg::rtcc_time_t  CUR_TIME_I,
  input  wire rtcc_pkg::rtcc_time_t  ALARM_TIME_I,
  input  wire rtcc_pkg::rtcc_roll_t  ROLL_I,
  input  wire logic [3:0]            TRIM_I,
  output logic                       CODING_BCD_O,
  output logic                       HALF_DAY_HOUR_MODE_O,
  output logic                       SEC_TICK_O,
  // Event outputs and summary sources
  input  wire logic [15:0]           SRC_EVENT_I,
  output logic                       PERIODIC_PULSE_O,
  output logic                       SQUARE_WAVE_O,
  output logic                       ALARM_O
);
  import rtcc_pkg::*;

  // Control register state
  logic                  coding_q, coding_d, half_day_hour_mode_q, half_day_hour_mode_d;
  logic                  seconds_halted_q, seconds_halted_d, alarm_halt_cmd_q, alarm_halt_cmd_d;
  logic [2:0]            periodic_pulse_select_q, periodic_pulse_select_d;
  logic [3:0]            square_wave_select_q, square_wave_select_d;
  // Time base state
  logic [ACC_W-1:0]      acc_q, acc_d;
  logic                  tick_q, tick_d;
  logic [PRESCALE_W-1:0] presc_q, presc_d;
  logic [3:0]            trim_q, trim_d;
  logic                  sec_tick_q, sec_tick_d, sqw_q, sqw_d;
  // Event state
  logic                  pend_q, pend_d, pulse_q, pulse_d;
  logic                  match_q, match_d, alarm_q, alarm_d;
  logic [2:0]            flags_q, flags_d, flag_set;
  logic [15:0]           summary_q, summary_d, sum_set;
  logic [15:0]           rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;
  // Combinational helpers
  logic                  ctrl_wr, ctrl_rd, sum_rd, flag_rd, event_sel, match_all;
  logic [5:0]            field_match;
  logic [5:0]            cur_hours, alm_hours;
  logic [3:0]            sqw_idx, trim_clamp;
  logic [ACC_W:0]        acc_sum;

  localparam logic [ACC_W:0] CORE_HZ_W = (ACC_W+1)'(CORE_HZ_P);
  localparam logic [ACC_W:0] BASE_HZ_W = (ACC_W+1)'(BASE_HZ);

  assign ctrl_wr = REG_REQ_I.wr && (REG_REQ_I.addr == TIME_CTRL_ADDR);
  assign ctrl_rd = REG_REQ_I.rd && (REG_REQ_I.addr == TIME_CTRL_ADDR);
  assign sum_rd  = REG_REQ_I.rd && (REG_REQ_I.addr == IRQ_SUMMARY_ADDR);
  assign flag_rd = REG_REQ_I.rd && (REG_REQ_I.addr == RTC_FLAGS_ADDR);

  // Control register
  always_comb begin
    coding_d                = coding_q;
    half_day_hour_mode_d    = half_day_hour_mode_q;
    seconds_halted_d        = seconds_halted_q;
    alarm_halt_cmd_d        = alarm_halt_cmd_q;
    periodic_pulse_select_d = periodic_pulse_select_q;
    square_wave_select_d    = square_wave_select_q;
    if (ctrl_wr) begin
      coding_d                = REG_REQ_I.wdata[CODING_BIT];
      half_day_hour_mode_d    = REG_REQ_I.wdata[HOUR_MODE_BIT];
      seconds_halted_d        = REG_REQ_I.wdata[CNT_HALT_BIT];
      alarm_halt_cmd_d        = REG_REQ_I.wdata[ALM_HALT_BIT];
      periodic_pulse_select_d = REG_REQ_I.wdata[PPS_HI:PPS_LO];
      square_wave_select_d    = REG_REQ_I.wdata[SQW_HI:SQW_LO];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      coding_q                <= CODING_RST;
      half_day_hour_mode_q    <= HOUR_MODE_RST;
      seconds_halted_q        <= CNT_HALT_RST;
      alarm_halt_cmd_q        <= ALM_HALT_RST;
      periodic_pulse_select_q <= PPS_RST;
      square_wave_select_q    <= SQW_RST;
    end else begin
      coding_q                <= coding_d;
      half_day_hour_mode_q    <= half_day_hour_mode_d;
      seconds_halted_q        <= seconds_halted_d;
      alarm_halt_cmd_q        <= alarm_halt_cmd_d;
      periodic_pulse_select_q <= periodic_pulse_select_d;
      square_wave_select_q    <= square_wave_select_d;
    end
  end

  // 32kHz enable by phase accumulation, exact on average since 40MHz is no multiple of it
  always_comb begin
    acc_sum    = {1'b0, acc_q} + BASE_HZ_W;
    trim_clamp = (TRIM_I > TRIM_MAX) ? TRIM_MAX : TRIM_I;
    tick_d     = (acc_sum >= CORE_HZ_W);
    acc_d      = tick_d ? ACC_W'(acc_sum - CORE_HZ_W) : acc_sum[ACC_W-1:0];
    presc_d    = presc_q;
    trim_d     = trim_q;
    sec_tick_d = 1'b0;
    if (tick_q && !seconds_halted_q) begin
      if (trim_q != 4'h0) begin
        // Prescaler parked at zero keeps the square wave low for the trim cycles
        trim_d = trim_q - 4'h1;
      end else begin
        presc_d = presc_q + 1'b1;
        if (presc_q == {PRESCALE_W{1'b1}}) begin
          sec_tick_d = 1'b1;
          trim_d     = trim_clamp;
        end
      end
    end
    sqw_idx = 4'(PRESCALE_W) - square_wave_select_q;
    sqw_d   = (square_wave_select_q != SQW_OFF) && presc_q[sqw_idx];
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      acc_q      <= '0;
      tick_q     <= 1'b0;
      presc_q    <= '0;
      trim_q     <= 4'h0;
      sec_tick_q <= 1'b0;
      sqw_q      <= 1'b0;
    end else begin
      acc_q      <= acc_d;
      tick_q     <= tick_d;
      presc_q    <= presc_d;
      trim_q     <= trim_d;
      sec_tick_q <= sec_tick_d;
      sqw_q      <= sqw_d;
    end
  end

  // Hours compare with PM bit only meaningful in 12-hour mode
  assign cur_hours = {CUR_TIME_I.pm & half_day_hour_mode_q, CUR_TIME_I.hours_field};
  // An all-ones hours field stays a wildcard in 24-hour mode, where the PM bit is masked off
  assign alm_hours = {(ALARM_TIME_I.pm & half_day_hour_mode_q) | (&ALARM_TIME_I.hours_field),
                      ALARM_TIME_I.hours_field};

  rtcc_field_match #(.W(7)) u_match_sec (
    .cur_i(CUR_TIME_I.seconds), .alarm_i(ALARM_TIME_I.seconds), .match_o(field_match[0]));
  rtcc_field_match #(.W(7)) u_match_min (
    .cur_i(CUR_TIME_I.minutes), .alarm_i(ALARM_TIME_I.minutes), .match_o(field_match[1]));
  rtcc_field_match #(.W(6)) u_match_hour (
    .cur_i(cur_hours), .alarm_i(alm_hours), .match_o(field_match[2]));
  rtcc_field_match #(.W(4)) u_match_day (
    .cur_i(CUR_TIME_I.day), .alarm_i(ALARM_TIME_I.day), .match_o(field_match[3]));
  rtcc_field_match #(.W(6)) u_match_date (
    .cur_i(CUR_TIME_I.date), .alarm_i(ALARM_TIME_I.date), .match_o(field_match[4]));
  rtcc_field_match #(.W(5)) u_match_month (
    .cur_i(CUR_TIME_I.month), .alarm_i(ALARM_TIME_I.month), .match_o(field_match[5]));

  assign match_all = &field_match;

  // Events, flags, summary and read port
  always_comb begin
    case (periodic_pulse_select_q)
      PPS_SEC:   event_sel = sec_tick_q;
      PPS_MIN:   event_sel = ROLL_I.minute;
      PPS_HOUR:  event_sel = ROLL_I.hour;
      PPS_DAY:   event_sel = ROLL_I.day;
      PPS_MONTH: event_sel = ROLL_I.month;
      default:   event_sel = 1'b0;
    endcase
    // Pending event waits for the next 32kHz edge so the pulse spans one full base cycle
    pend_d  = !seconds_halted_q && (event_sel || (pend_q && !tick_q));
    pulse_d = !seconds_halted_q && (tick_q ? pend_q : pulse_q);
    match_d = match_all;
    // Alarm only while the alarm circuitry runs; software halts it while reprogramming
    alarm_d = match_all && !match_q && !alarm_halt_cmd_q;
    flag_set[2] = pulse_d && !pulse_q;
    flag_set[1] = sec_tick_d && !sec_tick_q;
    flag_set[0] = alarm_d && !alarm_q;
    // Set wins over clear-on-read
    flags_d = (flag_rd ? 3'h0 : flags_q) | flag_set;
    sum_set = SRC_EVENT_I & SUMMARY_MASK;
    sum_set[RTC_SUMMARY_BIT] = |flag_set;
    summary_d = ((sum_rd ? WORD_ZERO : summary_q) | sum_set) & SUMMARY_MASK;
    rvalid_d = REG_REQ_I.rd;
    rdata_d  = rdata_q;
    if (REG_REQ_I.rd) begin
      rdata_d = WORD_ZERO;
      if (ctrl_rd) begin
        rdata_d[CODING_BIT]     = coding_q;
        rdata_d[HOUR_MODE_BIT]  = half_day_hour_mode_q;
        rdata_d[CNT_STS_BIT]    = seconds_halted_q;
        rdata_d[ALM_STS_BIT]    = alarm_halt_cmd_q;
        rdata_d[PPS_HI:PPS_LO]  = periodic_pulse_select_q;
        rdata_d[SQW_HI:SQW_LO]  = square_wave_select_q;
      end else if (sum_rd) begin
        rdata_d = summary_q;
      end else if (flag_rd) begin
        rdata_d[PERIODIC_FLAG_BIT:ALARM_FLAG_BIT] = flags_q;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pend_q    <= 1'b0;
      pulse_q   <= 1'b0;
      match_q   <= 1'b0;
      alarm_q   <= 1'b0;
      flags_q   <= FLAGS_RST;
      summary_q <= SUMMARY_RST;
      rdata_q   <= WORD_ZERO;
      rvalid_q  <= 1'b0;
    end else begin
      pend_q    <= pend_d;
      pulse_q   <= pulse_d;
      match_q   <= match_d;
      alarm_q   <= alarm_d;
      flags_q   <= flags_d;
      summary_q <= summary_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign REG_RDATA_O          = rdata_q;
  assign REG_RVALID_O         = rvalid_q;
  assign CODING_BCD_O         = coding_q;
  assign HALF_DAY_HOUR_MODE_O = half_day_hour_mode_q;
  assign SEC_TICK_O           = sec_tick_q;
  assign PERIODIC_PULSE_O     = pulse_q;
  assign SQUARE_WAVE_O        = sqw_q;
  assign ALARM_O              = alarm_q;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  cnt_halt_write_a : assert property (ctrl_wr |=> seconds_halted_q == $past(REG_REQ_I.wdata[CNT_HALT_BIT]))
    else $error("counter halt does not follow write");
  halt_status_read_a : assert property (ctrl_rd |=> REG_RDATA_O[CNT_STS_BIT] == $past(seconds_halted_q))
    else $error("counter status readback wrong");
  alarm_suppress_a : assert property (alarm_halt_cmd_q |=> !ALARM_O)
    else $error("alarm fired while halted");
  alarm_status_read_a : assert property (ctrl_rd |=> REG_RDATA_O[ALM_STS_BIT] == $past(alarm_halt_cmd_q))
    else $error("alarm status readback wrong");
  pulse_edge_a : assert property ($rose(PERIODIC_PULSE_O) |-> $past(tick_q))
    else $error("periodic pulse not aligned to base tick");
  pulse_halted_a : assert property (seconds_halted_q |=> !PERIODIC_PULSE_O)
    else $error("periodic pulse while counter stopped");
  sqw_off_a : assert property (square_wave_select_q == SQW_OFF |=> !SQUARE_WAVE_O)
    else $error("square wave active while off");
  trim_bound_a : assert property (trim_q <= TRIM_MAX)
    else $error("trim stall exceeds limit");
  summary_clear_a : assert property (sum_rd && sum_set == WORD_ZERO |=> summary_q == WORD_ZERO)
    else $error("summary not cleared by read");
  sec_flag_a : assert property ($rose(sec_tick_q) |-> flags_q[1])
    else $error("seconds flag not set on tick");
  rtc_summary_a : assert property (flag_set != 3'h0 |=> summary_q[RTC_SUMMARY_BIT])
    else $error("rtc summary bit not set");
endmodule : rtcc_control
`default_nettype wire

// ### rtcc_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin err_total++; $display("[ERR] %0t %s", $time, msg); end end
module rtcc_control_tb;
  import rtcc_pkg::*;
  localparam int SIM_HZ = 65536;
  localparam int LIMIT  = 90000;
  logic         clk, rstn, sqw, pulse, alarm, bcd, hmode, rvalid, stick;
  logic [3:0]   trim;
  logic [15:0]  rdata, src, d;
  rtcc_regreq_t req;
  rtcc_time_t   cur, alm;
  rtcc_roll_t   roll;
  int           err_total = 0, checked = 0, cyc = 0, n;
  int           bits[11] = '{13, 12, 9, 8, 7, 6, 5, 3, 2, 1, 0};

  rtcc_control #(.CORE_HZ_P(SIM_HZ)) dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CUR_TIME_I(cur), .ALARM_TIME_I(alm),
    .ROLL_I(roll), .TRIM_I(trim), .CODING_BCD_O(bcd), .HALF_DAY_HOUR_MODE_O(hmode),
    .SEC_TICK_O(stick), .SRC_EVENT_I(src), .PERIODIC_PULSE_O(pulse), .SQUARE_WAVE_O(sqw),
    .ALARM_O(alarm));
  rtcc_host_model host (.clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The run spans just over one 65536-cycle second; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] w);
    logic [15:0] r;
    logic        v;
    host.access(1'b1, a, w, r, v);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] q);
    logic [15:0] r;
    logic        v;
    host.access(1'b0, a, 16'h0000, r, v);
    q = (v === 1'b1) ? r : 16'hxxxx;
  endtask : reg_rd

  task automatic roll_count(output int k);
    k = 0;
    @(negedge clk);
    roll = 4'hf;
    @(negedge clk);
    roll = 4'h0;
    repeat (12) begin
      @(negedge clk);
      if (pulse === 1'b1) k++;
    end
  endtask : roll_count

  task automatic high_time(output int k);
    k = 0;
    repeat (100) begin
      @(negedge clk);
      if (sqw === 1'b0) break;
    end
    repeat (100) begin
      @(negedge clk);
      if (sqw === 1'b1) break;
    end
    while (sqw === 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
  endtask : high_time

  task automatic alarm_count(output int k);
    k = 0;
    repeat (6) begin
      @(negedge clk);
      if (alarm === 1'b1) k++;
    end
  endtask : alarm_count

  task automatic test_reset_and_modes();
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d & 16'hc5ff, 16'h0120, "control reset value")
    `CHK(d[ALM_STS_BIT], 1'b1, "alarm status after reset")
    `CHK(d[PPS_HI:PPS_LO], PPS_MIN, "pulse select default")
    `CHK({bcd, hmode}, 2'b00, "coding and hour mode reset")
    reg_wr(TIME_CTRL_ADDR, 16'hc220);
    `CHK(bcd, 1'b1, "coding bit not applied")
    `CHK(hmode, 1'b1, "hour mode not applied")
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d[15:14], 2'b11, "coding and hour readback")
    reg_wr(TIME_CTRL_ADDR, 16'h0220);
    `CHK({bcd, hmode}, 2'b00, "coding and hour cleared")
    reg_wr(8'h20, 16'hffff);
    reg_rd(8'h20, d);
    `CHK(d, 16'h0000, "unmapped read")
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d & 16'hc5ff, 16'h0120, "unmapped write leaked")
  endtask : test_reset_and_modes

  task automatic test_periodic();
    for (int c = 0; c < 8; c++) begin
      reg_wr(TIME_CTRL_ADDR, 16'h0200 | (16'(c) << 4));
      roll_count(n);
      `CHK(n, (c >= 2 && c <= 5) ? 2 : 0, "periodic pulse per code")
    end
    reg_rd(RTC_FLAGS_ADDR, d);
    reg_rd(IRQ_SUMMARY_ADDR, d);
    reg_wr(TIME_CTRL_ADDR, 16'h0220);
    roll_count(n);
    `CHK(n, 2, "pulse width one time base period")
    reg_rd(RTC_FLAGS_ADDR, d);
    `CHK(d & 16'h00e0, 16'h0080, "periodic flag")
    reg_rd(RTC_FLAGS_ADDR, d);
    `CHK(d & 16'h00e0, 16'h0000, "flags not cleared by read")
    reg_rd(IRQ_SUMMARY_ADDR, d);
    `CHK(d, 16'h0010, "rtc summary bit")
    reg_rd(IRQ_SUMMARY_ADDR, d);
    `CHK(d, 16'h0000, "summary not cleared by read")
  endtask : test_periodic

  task automatic test_halt();
    reg_wr(TIME_CTRL_ADDR, 16'h0a20);
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d[CNT_STS_BIT], 1'b1, "halt status while stopped")
    roll_count(n);
    `CHK(n, 0, "pulse while counter stopped")
    reg_wr(TIME_CTRL_ADDR, 16'h0220);
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d[CNT_STS_BIT], 1'b0, "halt status while running")
    roll_count(n);
    `CHK(n, 2, "pulse after restart")
  endtask : test_halt

  task automatic test_alarm();
    n = 0;
    cur.seconds = 7'h05;
    repeat (6) begin
      @(negedge clk);
      if (alarm === 1'b1) n++;
    end
    `CHK(n, 0, "alarm while halted")
    cur.seconds = 7'h00;
    // Alarm fields are set up while halted, then alarms are enabled
    alm.minutes = 7'h7f;
    reg_wr(TIME_CTRL_ADDR, 16'h0020);
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d[ALM_STS_BIT], 1'b0, "alarm status running")
    reg_rd(RTC_FLAGS_ADDR, d);
    reg_rd(IRQ_SUMMARY_ADDR, d);
    @(negedge clk);
    cur.seconds = 7'h05;
    repeat (6) begin
      @(negedge clk);
      if (alarm === 1'b1) n++;
    end
    `CHK(n, 1, "alarm with wildcard fields")
    reg_rd(RTC_FLAGS_ADDR, d);
    `CHK(d & 16'h00e0, 16'h0020, "alarm flag")
    reg_rd(IRQ_SUMMARY_ADDR, d);
    `CHK(d, 16'h0010, "rtc summary from alarm")
    // Hours now compared; PM bit of the alarm is set, the time's is clear
    alm.hours_field = 5'h03;
    cur.hours_field = 5'h03;
    reg_wr(TIME_CTRL_ADDR, 16'h4020);
    alarm_count(n);
    `CHK(n, 0, "alarm despite pm mismatch in 12-hour mode")
    cur.pm = 1'b1;
    alarm_count(n);
    `CHK(n, 1, "no alarm on 12-hour pm match")
    reg_wr(TIME_CTRL_ADDR, 16'h0220);
    reg_rd(TIME_CTRL_ADDR, d);
    `CHK(d[ALM_STS_BIT], 1'b1, "alarm status halted again")
  endtask : test_alarm

  task automatic test_square();
    for (int s = 13; s < 16; s++) begin
      reg_wr(TIME_CTRL_ADDR, 16'h0220 | 16'(s));
      high_time(n);
      `CHK(n, 2 << (15 - s), "square wave half period")
    end
    reg_wr(TIME_CTRL_ADDR, 16'h0220);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (sqw !== 1'b0) n++;
    end
    `CHK(n, 0, "square wave when disabled")
  endtask : test_square

  task automatic test_summary();
    reg_rd(IRQ_SUMMARY_ADDR, d);
    foreach (bits[i]) begin
      @(negedge clk);
      src = 16'h0001 << bits[i];
      @(negedge clk);
      src = 16'h0000;
      reg_rd(IRQ_SUMMARY_ADDR, d);
      `CHK(d, 16'h0001 << bits[i], "summary bit position")
    end
    @(negedge clk);
    src = 16'hffff;
    @(negedge clk);
    src = 16'h0000;
    reg_rd(IRQ_SUMMARY_ADDR, d);
    `CHK(d, 16'h33ef, "summary all groups")
    reg_rd(IRQ_SUMMARY_ADDR, d);
    `CHK(d, 16'h0000, "summary clear on read")
  endtask : test_summary

  task automatic test_second();
    reg_wr(TIME_CTRL_ADDR, 16'h021f);
    reg_rd(RTC_FLAGS_ADDR, d);
    n = 0;
    while (stick !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    `CHK(stick, 1'b1, "no seconds tick within a second")
    // Normal low half period is one base cycle, trim adds the clamped stall
    n = 0;
    @(negedge clk);
    while (sqw === 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, 2 + 2 * int'(TRIM_MAX), "trim stretch of square wave low time")
    reg_rd(RTC_FLAGS_ADDR, d);
    `CHK(d & 16'h00e0, 16'h00c0, "seconds and periodic flags")
  endtask : test_second

  initial begin
    rstn = 1'b0;
    src = 16'h0000;
    roll = 4'h0;
    cur = '0;
    trim = 4'hf;
    alm = '1;
    alm.seconds = 7'h05;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    test_reset_and_modes();
    test_periodic();
    test_halt();
    test_alarm();
    test_square();
    test_summary();
    test_second();
    summarize();
  end
endmodule : rtcc_control_tb
`default_nettype wire

// ### rtcc_field_match.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_field_match #(
  parameter int W = 7
) (
  input  wire logic [W-1:0] cur_i,
  input  wire logic [W-1:0] alarm_i,
  output logic              match_o
);
  // An all-ones alarm value matches any time value
  assign match_o = (alarm_i == {W{1'b1}}) || (alarm_i == cur_i);
endmodule : rtcc_field_match
`default_nettype wire

// ### rtcc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_host_model (
  // Clock
  input  wire logic                   clk_i,
  // Register port of the block
  output var rtcc_pkg::rtcc_regreq_t  req_o,
  input  wire logic [15:0]            rdata_i,
  input  wire logic                   rvalid_i
);
  import rtcc_pkg::*;

  initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 16'hffff};

  // One-cycle strobe; idle address and data are flipped so a stale word never looks valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic valid);
    @(negedge clk_i);
    req_o = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
    @(negedge clk_i);
    valid = rvalid_i;
    rdata = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access
endmodule : rtcc_host_model
`default_nettype wire

// ### rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;
  // Register addresses
  localparam logic [7:0]  TIME_CTRL_ADDR   = 8'h17;
  localparam logic [7:0]  IRQ_SUMMARY_ADDR = 8'h18;
  localparam logic [7:0]  RTC_FLAGS_ADDR   = 8'h19;

  // Time control fields
  localparam int          CODING_BIT    = 15;
  localparam int          HOUR_MODE_BIT = 14;
  localparam int          CNT_HALT_BIT  = 11;
  localparam int          CNT_STS_BIT   = 10;
  localparam int          ALM_HALT_BIT  = 9;
  localparam int          ALM_STS_BIT   = 8;
  localparam int          PPS_LO        = 4;
  localparam int          PPS_HI        = 6;
  localparam int          SQW_LO        = 0;
  localparam int          SQW_HI        = 3;

  localparam logic        CODING_RST    = 1'b0;
  localparam logic        HOUR_MODE_RST = 1'b0;
  localparam logic        CNT_HALT_RST  = 1'b0;
  localparam logic        ALM_HALT_RST  = 1'b1;
  localparam logic [2:0]  PPS_RST       = 3'h2;
  localparam logic [3:0]  SQW_RST       = 4'h0;

  // Periodic pulse selector codes, 11x is off
  localparam logic [2:0]  PPS_OFF   = 3'h0;
  localparam logic [2:0]  PPS_SEC   = 3'h1;
  localparam logic [2:0]  PPS_MIN   = 3'h2;
  localparam logic [2:0]  PPS_HOUR  = 3'h3;
  localparam logic [2:0]  PPS_DAY   = 3'h4;
  localparam logic [2:0]  PPS_MONTH = 3'h5;
  localparam logic [3:0]  SQW_OFF   = 4'h0;

  // Summary register layout
  localparam int          OVERCURRENT_BIT  = 13;
  localparam int          UNDERVOLTAGE_BIT = 12;
  localparam int          SINK_BIT         = 9;
  localparam int          EXTERNAL_BIT     = 8;
  localparam int          CODEC_BIT        = 7;
  localparam int          GPIO_BIT         = 6;
  localparam int          COMPARATOR_BIT   = 5;
  localparam int          RTC_SUMMARY_BIT  = 4;
  localparam int          SYSTEM_BIT       = 3;
  localparam int          CHARGER_BIT      = 2;
  localparam int          USB_BIT          = 1;
  localparam int          WAKEUP_BIT       = 0;
  localparam logic [15:0] SUMMARY_MASK     = 16'h33ff;
  localparam logic [15:0] SUMMARY_RST      = 16'h0000;

  // Second-level RTC flags
  localparam int          PERIODIC_FLAG_BIT = 7;
  localparam int          SEC_FLAG_BIT      = 6;
  localparam int          ALARM_FLAG_BIT    = 5;
  localparam logic [2:0]  FLAGS_RST         = 3'h0;

  // Time base
  localparam int          BASE_HZ    = 32768;
  localparam int          CORE_HZ    = 40_000_000;
  localparam int          ACC_W      = 27;
  localparam int          PRESCALE_W = 15;
  localparam logic [3:0]  TRIM_MAX   = 4'h8;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  typedef struct packed {
    logic [4:0] month;
    logic [5:0] date;
    logic [3:0] day;
    logic       pm;
    logic [4:0] hours_field;
    logic [6:0] minutes;
    logic [6:0] seconds;
  } rtcc_time_t;

  typedef struct packed {
    logic month;
    logic day;
    logic hour;
    logic minute;
  } rtcc_roll_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } rtcc_regreq_t;
endpackage : rtcc_pkg
`default_nettype wire
